// >>> hw/dstm_map.vh
// Register offsets, field positions, reset values and timing counts of the timing monitor
`ifndef DSTM_MAP_VH
`define DSTM_MAP_VH
`define DSTM_ADDR_W        5
`define DSTM_OFF_CTRL      5'h03
`define DSTM_OFF_DMARGIN   5'h04
`define DSTM_OFF_DELAY     5'h05
`define DSTM_OFF_SYNCCFG   5'h06
`define DSTM_OFF_SMARGIN   5'h07
`define DSTM_OFF_IRQMASK   5'h08
`define DSTM_OFF_IRQSTAT   5'h19
`define DSTM_CTRL_AUTO     7
`define DSTM_CTRL_DLY_EN   6
`define DSTM_CTRL_REFERENCE_CLOCK_INPUT   0
`define DSTM_STAT_DERR     0
`define DSTM_STAT_SERR     1
`define DSTM_STAT_DTYPE    2
`define DSTM_CTRL_RST      8'h00
`define DSTM_MASK_RST      8'h00
`define DSTM_RATIO_RST     3'h0
`define DSTM_PHASE_RST     5'h00
`define DSTM_MARGIN_RST    4'h0
`define DSTM_DELAY_RST     5'h00
`define DSTM_STATES        32
`define DSTM_ZERO_DELAY_PS 700
`define DSTM_UNIT_DELAY_PS 190
`endif

// >>> hw/dstm_margin_check.v
// Margin sampler: compares early and late copies of a sampled bus against the real sample
`timescale 1ns/1ps
`default_nettype none
module dstm_margin_check #(
    parameter W = 16
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         enable,
    input  wire         sample_en,
    input  wire [3:0]   margin,
    input  wire [W-1:0] data_in,
    output reg          err_pulse,
    output reg          err_is_setup
);
    // Taps one cycle per margin step apart; tap index = margin steps before and after
    reg  [W-1:0] tap_reg [0:32];
    integer      i;
    wire [5:0]   mid      = 6'd16;
    wire [5:0]   early_ix = mid + {2'b00, margin};
    wire [5:0]   late_ix  = mid - {2'b00, margin};
    wire         early_bad = (tap_reg[early_ix] != tap_reg[mid]);
    wire         late_bad  = (tap_reg[late_ix] != tap_reg[mid]);
    always @(posedge ref_clk) begin
        tap_reg[0] <= data_in;
        for (i = 1; i <= 32; i = i + 1) begin
            tap_reg[i] <= tap_reg[i-1];
        end
    end
    always @(posedge ref_clk) begin
        if (rst) begin
            err_pulse    <= 1'b0;
            err_is_setup <= 1'b0;
        end else begin
            // Zero margin collapses both copies onto the real sample, so it never flags
            err_pulse <= enable && sample_en && (early_bad || late_bad);
            if (enable && sample_en && (early_bad || late_bad)) begin
                err_is_setup <= early_bad;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/dstm_top.v
// Data and sync timing monitor with delay control, clock-state sync and open-drain alert
// Behaviour
// - Early and late copies of each word; mismatch with real sample is data error
// - Four-bit data margin sets copy spacing; error when margin below setting
// - Error type bit: low means hold violation, high means setup violation
// - In manual mode the programmed data clock delay code is never altered
// - Delay enable resets off; delay code applies only once host sets it
// - Delay grows monotonically, about 700 ps at zero plus 190 ps per step
// - Manual mode activates data error checking; sync checking runs in every mode; unmasked violations raise the alert
// - One check per configuration; margin or delay change starts a fresh check
// - Sync makes a one-cycle pulse loading the five-bit initial phase state
// - Clock state machine has 32 states; timely pulses reload the same state
// - Sync ratio selects 1,2,4,8,16 rising edges per pulse; 101-111 invalid
// - Each phase increment advances derived clocks one sample cycle versus sync
// - Four-bit sync margin governs sync checking; error when margin below setting
// - Single pulse or periodic sync accepted, sampled by the sample clock
// - Alert output is open drain, active low, wire-OR capable
// - Both error flags assert alert by default, each maskable separately
// - Flags stick until status register is read or flag bits overwritten
// - Data timing checks apply only when data is timed to data clock output
`timescale 1ns/1ps
`default_nettype none
`include "dstm_map.vh"
module dstm_top #(
    parameter DATA_W = 16
) (
    input  wire              ref_clk,
    input  wire              rst,
    input  wire [4:0]        reg_addr,
    input  wire [7:0]        reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [7:0]        reg_rdata,
    input  wire              data_clock_output_in,
    input  wire [DATA_W-1:0] data_in,
    input  wire              sync_in,
    output reg  [DATA_W-1:0] data_sample_reg,
    output reg  [4:0]        data_clock_delay_code,
    output reg               delay_active,
    output reg  [15:0]       delay_ps,
    output reg  [4:0]        clock_state,
    output reg               init_pulse,
    output reg               data_sample_clock,
    output wire              irq_n_out,
    output wire              irq_n_oe
);
    localparam [5:0] STATES = `DSTM_STATES;

    reg [7:0] ctrl_reg;
    reg [3:0] dmargin_reg;
    reg [4:0] delay_reg;
    reg [2:0] ratio_reg;
    reg [4:0] phase_reg;
    reg [3:0] smargin_reg;
    reg [1:0] mask_reg;
    reg       derr_reg;
    reg       serr_reg;
    reg       dtype_reg;
    reg       check_armed_reg;

    // Two-flop synchronisers for pins from outside the clock domain
    reg [DATA_W-1:0] din_s1, din_s2;
    reg              dck_s1, dck_s2, dck_s3;
    reg              syn_s1, syn_s2, syn_s3;
    always @(posedge ref_clk) begin
        din_s1 <= data_in;
        din_s2 <= din_s1;
        dck_s1 <= data_clock_output_in;
        dck_s2 <= dck_s1;
        dck_s3 <= dck_s2;
        syn_s1 <= sync_in;
        syn_s2 <= syn_s1;
        syn_s3 <= syn_s2;
    end
    wire dck_rise  = dck_s2 & ~dck_s3;
    wire sync_rise = syn_s2 & ~syn_s3;

    function [4:0] ratio_edges;
        input [2:0] code;
        begin
            case (code)
                3'h0: ratio_edges = 5'h01;
                3'h1: ratio_edges = 5'h02;
                3'h2: ratio_edges = 5'h04;
                3'h3: ratio_edges = 5'h08;
                3'h4: ratio_edges = 5'h10;
                default: ratio_edges = 5'h00;
            endcase
        end
    endfunction

    wire manual_mode = ~ctrl_reg[`DSTM_CTRL_AUTO];
    wire data_ref_ok = ~ctrl_reg[`DSTM_CTRL_REFERENCE_CLOCK_INPUT];
    wire check_en    = manual_mode & data_ref_ok & check_armed_reg;

    wire wr_ctrl    = reg_wr && (reg_addr == `DSTM_OFF_CTRL);
    wire wr_dmargin = reg_wr && (reg_addr == `DSTM_OFF_DMARGIN);
    wire wr_delay   = reg_wr && (reg_addr == `DSTM_OFF_DELAY);
    wire wr_stat    = reg_wr && (reg_addr == `DSTM_OFF_IRQSTAT);
    wire rd_stat    = reg_rd && (reg_addr == `DSTM_OFF_IRQSTAT);

    wire derr_pulse;
    wire derr_setup;
    dstm_margin_check #(
        .W(DATA_W)
    ) u_data_chk (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .enable      (check_en),
        .sample_en   (dck_rise),
        .margin      (dmargin_reg),
        .data_in     (din_s2),
        .err_pulse   (derr_pulse),
        .err_is_setup(derr_setup)
    );

    wire serr_pulse;
    dstm_margin_check #(
        .W(1)
    ) u_sync_chk (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .enable      (1'b1),
        .sample_en   (sync_rise),
        .margin      (smargin_reg),
        .data_in     (syn_s2),
        .err_pulse   (serr_pulse),
        .err_is_setup()
    );

    // Register file
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg    <= `DSTM_CTRL_RST;
            dmargin_reg <= `DSTM_MARGIN_RST;
            delay_reg   <= `DSTM_DELAY_RST;
            ratio_reg   <= `DSTM_RATIO_RST;
            phase_reg   <= `DSTM_PHASE_RST;
            smargin_reg <= `DSTM_MARGIN_RST;
            mask_reg    <= 2'b00;
        end else if (reg_wr) begin
            case (reg_addr)
                `DSTM_OFF_CTRL:    ctrl_reg    <= reg_wdata;
                `DSTM_OFF_DMARGIN: dmargin_reg <= reg_wdata[3:0];
                // Only software writes the code; no automatic search alters it
                `DSTM_OFF_DELAY:   delay_reg   <= reg_wdata[4:0];
                `DSTM_OFF_SYNCCFG: begin
                    ratio_reg <= reg_wdata[7:5];
                    phase_reg <= reg_wdata[4:0];
                end
                `DSTM_OFF_SMARGIN: smargin_reg <= reg_wdata[3:0];
                `DSTM_OFF_IRQMASK: mask_reg    <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // One check per configuration: arm on change, disarm after the first error
    always @(posedge ref_clk) begin
        if (rst) begin
            check_armed_reg <= 1'b0;
        end else if (wr_dmargin || wr_delay || wr_ctrl) begin
            check_armed_reg <= 1'b1;
        end else if (derr_pulse) begin
            check_armed_reg <= 1'b0;
        end
    end

    // Sticky flags; a new error in the clear cycle wins
    always @(posedge ref_clk) begin
        if (rst) begin
            derr_reg  <= 1'b0;
            serr_reg  <= 1'b0;
            dtype_reg <= 1'b0;
        end else begin
            if (derr_pulse) begin
                derr_reg  <= 1'b1;
                dtype_reg <= derr_setup;
            end else if (rd_stat) begin
                derr_reg <= 1'b0;
            end else if (wr_stat) begin
                derr_reg  <= reg_wdata[`DSTM_STAT_DERR];
                dtype_reg <= reg_wdata[`DSTM_STAT_DTYPE];
            end
            if (serr_pulse) begin
                serr_reg <= 1'b1;
            end else if (rd_stat) begin
                serr_reg <= 1'b0;
            end else if (wr_stat) begin
                serr_reg <= reg_wdata[`DSTM_STAT_SERR];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero
    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `DSTM_OFF_CTRL:    reg_rdata <= ctrl_reg;
                `DSTM_OFF_DMARGIN: reg_rdata <= {4'h0, dmargin_reg};
                `DSTM_OFF_DELAY:   reg_rdata <= {3'h0, delay_reg};
                `DSTM_OFF_SYNCCFG: reg_rdata <= {ratio_reg, phase_reg};
                `DSTM_OFF_SMARGIN: reg_rdata <= {4'h0, smargin_reg};
                `DSTM_OFF_IRQMASK: reg_rdata <= {6'h00, mask_reg};
                `DSTM_OFF_IRQSTAT: reg_rdata <= {5'h00, dtype_reg, serr_reg, derr_reg};
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Delay code and nominal delay figure
    always @(posedge ref_clk) begin
        if (rst) begin
            data_clock_delay_code <= 5'h00;
            delay_active          <= 1'b0;
            delay_ps              <= 16'h0000;
        end else begin
            delay_active <= ctrl_reg[`DSTM_CTRL_DLY_EN];
            if (ctrl_reg[`DSTM_CTRL_DLY_EN]) begin
                data_clock_delay_code <= delay_reg;
                // Monotonic: zero-code offset plus fixed step per code
                delay_ps <= 16'd`DSTM_ZERO_DELAY_PS
                          + delay_reg * 16'd`DSTM_UNIT_DELAY_PS;
            end else begin
                data_clock_delay_code <= 5'h00;
                delay_ps              <= 16'h0000;
            end
        end
    end

    // Sync edge counter; invalid ratio codes make no pulses at all
    reg [4:0] edge_cnt_reg;
    wire [4:0] need = ratio_edges(ratio_reg);
    wire       fire = sync_rise && (need != 5'h00) && (edge_cnt_reg + 5'h01 >= need);
    always @(posedge ref_clk) begin
        if (rst) begin
            edge_cnt_reg <= 5'h00;
            init_pulse   <= 1'b0;
        end else begin
            init_pulse <= fire;
            if (fire) begin
                edge_cnt_reg <= 5'h00;
            end else if (sync_rise && need != 5'h00) begin
                edge_cnt_reg <= edge_cnt_reg + 5'h01;
            end
        end
    end

    // 32-state clock generator; pulse loads phase so later timely pulses change nothing
    always @(posedge ref_clk) begin
        if (rst) begin
            clock_state       <= 5'h00;
            data_sample_clock <= 1'b0;
        end else begin
            if (init_pulse) begin
                clock_state <= phase_reg;
            end else begin
                clock_state <= clock_state + 5'h01;
            end
            data_sample_clock <= (clock_state < STATES[5:1]);
        end
    end

    // Open drain: only ever drives low, enable low while driving
    wire irq_any = (derr_reg & ~mask_reg[0]) | (serr_reg & ~mask_reg[1]);
    assign irq_n_out = 1'b0;
    assign irq_n_oe  = ~irq_any;

    always @(posedge ref_clk) begin
        data_sample_reg <= rst ? {DATA_W{1'b0}} : (dck_rise ? din_s2 : data_sample_reg);
    end
endmodule
`default_nettype wire

// >>> tb/dstm_monitor.sv
// Checker of the timing monitor port behaviour
`timescale 1ns/1ps
`default_nettype none
`include "dstm_map.vh"
module dstm_monitor (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [4:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [4:0]  data_clock_delay_code,
    input wire logic        delay_active,
    input wire logic [15:0] delay_ps,
    input wire logic [4:0]  clock_state,
    input wire logic        init_pulse,
    input wire logic        irq_n_out,
    input wire logic        irq_n_oe
);
    logic [1:0] mask_h;
    logic [7:0] sync_h;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    always @(posedge ref_clk) begin
        if (rst) begin
            mask_h <= 2'h0;
            sync_h <= 8'h00;
        end else if (reg_wr && reg_addr == `DSTM_OFF_IRQMASK) begin
            mask_h <= reg_wdata[1:0];
        end else if (reg_wr && reg_addr == `DSTM_OFF_SYNCCFG) begin
            sync_h <= reg_wdata;
        end
    end
    sequence s_pulse; init_pulse; endsequence
    sequence s_hold; !irq_n_oe && mask_h == 2'h0 && !reg_wr && !reg_rd; endsequence
    property p_width; s_pulse |=> !init_pulse; endproperty
    property p_load; s_pulse |=> clock_state == sync_h[4:0]; endproperty
    property p_step; !init_pulse |=> clock_state == $past(clock_state) + 5'h01; endproperty
    property p_delay; $stable(delay_active) && $stable(data_clock_delay_code) |->
        delay_ps == (delay_active ? 16'd700 + 16'd190 * data_clock_delay_code : 16'h0000);
    endproperty
    property p_off; !delay_active [*2] |-> data_clock_delay_code == 5'h00; endproperty
    property p_od; irq_n_out == 1'b0; endproperty
    property p_mask; (mask_h == 2'h3) [*2] |-> irq_n_oe; endproperty
    property p_inval; (sync_h[7:5] > 3'h4) [*8] |-> !init_pulse; endproperty
    property p_sticky; s_hold |=> !irq_n_oe; endproperty
    a_width: assert property (p_width) else $error("init pulse too wide");
    a_load: assert property (p_load) else $error("phase not loaded");
    a_step: assert property (p_step) else $error("state did not step");
    a_delay: assert property (p_delay) else $error("delay value wrong");
    a_off: assert property (p_off) else $error("delay code while disabled");
    a_od: assert property (p_od) else $error("alert drives high");
    a_mask: assert property (p_mask) else $error("masked alert active");
    a_inval: assert property (p_inval) else $error("pulse on invalid ratio");
    a_sticky: assert property (p_sticky) else $error("alert dropped early");
endmodule
bind dstm_top dstm_monitor mon_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .data_clock_delay_code(data_clock_delay_code), .delay_active(delay_active),
    .delay_ps(delay_ps), .clock_state(clock_state), .init_pulse(init_pulse),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
`default_nettype wire

// >>> tb/dstm_src.sv
// Data source and sync distributor model at the monitor's far side
`timescale 1ns/1ps
`default_nettype none
module dstm_src (
    output logic            dclk,
    output logic [15:0]     data,
    output logic            sync,
    input  wire logic [1:0] skew
);
    int seed = 45;
    initial begin
        dclk = 1'b0;
        data = 16'h0000;
        sync = 1'b0;
    end
    always #100 dclk = ~dclk;
    // Skew 1 changes data just after the rise, skew 2 just before the next one
    always @(posedge dclk) begin
        #(skew == 2'd1 ? 20 : skew == 2'd2 ? 180 : 100);
        data = $random(seed);
    end
    // One rise per 32 sample clocks keeps reloads landing on the same state
    initial forever begin
        #700 sync = 1'b1;
        #100 sync = 1'b0;
    end
endmodule
`default_nettype wire

// >>> tb/tb_dstm_top.sv
// Self-checking bench of the timing monitor
`timescale 1ns/1ps
`default_nettype none
`include "dstm_map.vh"
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin num_errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module tb_dstm_top;
    logic        ref_clk, rst, reg_wr, reg_rd, rd_seen;
    logic [4:0]  reg_addr, ph, d;
    logic [7:0]  reg_wdata, e_v;
    logic [1:0]  skew;
    logic [7:0]  exp_q[$];
    wire  [7:0]  reg_rdata;
    wire  [15:0] data, dps;
    wire  [4:0]  code, cst;
    wire         dclk, sync, dact, ip, irq_o, irq_oe;
    int          num_errors = 0, cmp_count = 0, seed = 45, n;
    dstm_top dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_clock_output_in(dclk), .data_in(data), .sync_in(sync), .data_sample_reg(),
        .data_clock_delay_code(code), .delay_active(dact), .delay_ps(dps),
        .clock_state(cst), .init_pulse(ip), .data_sample_clock(),
        .irq_n_out(irq_o), .irq_n_oe(irq_oe));
    dstm_src src_u (.dclk(dclk), .data(data), .sync(sync), .skew(skew));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            e_v = exp_q.pop_front();
            `CHK("rdata", e_v, reg_rdata)
        end
        rd_seen <= reg_rd && !rst;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic wp(input int lim, input bit must);
        n = 0;
        while (ip !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        if (must && n >= lim) begin
            num_errors++;
            results();
        end
    endtask
    task results;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    logic [1:0] sk_t[5] = '{2'd1, 2'd2, 2'd2, 2'd1, 2'd0};
    logic [7:0] mk_t[5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [7:0] ct_t[5] = '{8'h40, 8'h40, 8'h40, 8'h41, 8'h40};
    logic [7:0] st_t[5] = '{8'h01, 8'h05, 8'h05, 8'h00, 8'h00};
    initial begin
        {rst, reg_wr, reg_rd, rd_seen, reg_addr, reg_wdata, skew} = {4'h8, 15'h0};
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(4);
        rd(`DSTM_OFF_CTRL, `DSTM_CTRL_RST);
        rd(`DSTM_OFF_IRQMASK, `DSTM_MASK_RST);
        rd(`DSTM_OFF_IRQSTAT, 8'h00);
        rd(5'h1f, 8'h00);
        `CHK("oe", 1'b1, irq_oe)
        wr(`DSTM_OFF_DELAY, 8'h1f);
        cyc(3);
        `CHK("code", 5'h00, code)
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($random(seed));
            wr(`DSTM_OFF_DELAY, {3'h0, d});
            wr(`DSTM_OFF_CTRL, 8'h40);
            cyc(3);
            `CHK("code", d, code)
            `CHK("ps", 16'(700 + 190 * d), dps)
            rd(`DSTM_OFF_DELAY, {3'h0, d});
        end
        // Ctrl before margin so a reference-clock case never arms with the old setting
        for (int i = 0; i < 5; i++) begin
            skew <= sk_t[i];
            // Let words of the old skew leave the margin taps before a check arms
            cyc(40);
            wr(`DSTM_OFF_IRQMASK, mk_t[i]);
            wr(`DSTM_OFF_CTRL, ct_t[i]);
            wr(`DSTM_OFF_DMARGIN, 8'h02);
            cyc(60);
            `CHK("oe", st_t[i][0] & !mk_t[i][0] ? 1'b0 : 1'b1, irq_oe)
            rd(`DSTM_OFF_IRQSTAT, st_t[i]);
            cyc(60);
            // Read clears only the two flags; the type bit survives until written
            rd(`DSTM_OFF_IRQSTAT, st_t[i] & 8'h04);
            wr(`DSTM_OFF_IRQSTAT, 8'h02);
            cyc(2);
            `CHK("oe", 1'b0, irq_oe)
            wr(`DSTM_OFF_IRQSTAT, 8'h00);
            cyc(2);
            `CHK("oe", 1'b1, irq_oe)
        end
        // Wide sync margin reaches the previous sync pulse, so the sync flag sets
        wr(`DSTM_OFF_SMARGIN, 8'h0f);
        cyc(70);
        wr(`DSTM_OFF_SMARGIN, 8'h00);
        cyc(3);
        rd(`DSTM_OFF_IRQSTAT, 8'h02);
        cyc(70);
        rd(`DSTM_OFF_IRQSTAT, 8'h00);
        for (int r = 0; r < 6; r++) begin
            ph = 5'($random(seed));
            wr(`DSTM_OFF_SYNCCFG, {r[2:0], ph});
            if (r == 5) begin
                cyc(8);
                wp(1100, 1'b0);
                `CHK("nopulse", 1100, n)
            end else begin
                wp(600, 1'b1);
                @(posedge ref_clk);
                wp(600, 1'b1);
                @(posedge ref_clk);
                `CHK("state", ph, cst)
                wp(600, 1'b1);
                `CHK("period", 32 << r, n + 1)
                @(posedge ref_clk);
                `CHK("state", ph, cst)
            end
        end
        results();
    end
endmodule
`default_nettype wire
